// File: src/aop_port.sv
// result output port: phase indicator, result latch, byte lanes and apb registers
//
// Chosen here: the register offsets and register access over APB.
`default_nettype none
module aop_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire aop_pkg::aop_phase_t analog_phase_i,
  input wire logic [12:0] conv_count_i,
  input wire logic conv_positive_i,
  input wire logic test_n_i,
  input wire logic chip_enable_n_i,
  input wire logic low_byte_gate_n_i,
  input wire logic high_byte_gate_n_i,
  output logic status_o,
  output logic [7:0] result_low_o,
  output logic low_oe_n_o,
  output logic [5:0] result_high_o,
  output logic high_oe_n_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  aop_pkg::aop_state_t state_reg;
  aop_pkg::aop_state_t state_next;
  logic status_reg;
  logic status_next;
  aop_pkg::aop_result_t latch_reg;
  aop_pkg::aop_result_t latch_next;
  aop_pkg::aop_result_t sample;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic in_quiet_phase;

  // conversion sequencing and result latch
  always_comb begin
    sample.sign_flag = conv_positive_i;
    sample.over_range = conv_count_i > aop_pkg::FULL_SCALE;
    sample.magnitude = conv_count_i[aop_pkg::MAG_W-1:0];
    in_quiet_phase = (analog_phase_i == aop_pkg::PH_AUTO_ZERO) || (analog_phase_i == aop_pkg::PH_ZERO_INT);
    state_next = state_reg;
    status_next = status_reg;
    latch_next = latch_reg;
    count_next = count_reg;
    unique case (state_reg)
      aop_pkg::ST_QUIET: begin
        status_next = 1'b0;
        if (analog_phase_i == aop_pkg::PH_INTEGRATE) begin
          state_next = aop_pkg::ST_BUSY;
          status_next = 1'b1;
        end
      end
      aop_pkg::ST_BUSY: begin
        // the latch closes on the same edge the indicator falls
        if (in_quiet_phase) begin
          state_next = aop_pkg::ST_QUIET;
          status_next = 1'b0;
          latch_next = sample;
          count_next = count_reg + 16'h0001;
        end
      end
      default: begin
        state_next = aop_pkg::ST_QUIET;
        status_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= aop_pkg::ST_QUIET;
      status_reg <= 1'b0;
      latch_reg <= '0;
      count_reg <= aop_pkg::COUNT_RESET;
    end else begin
      state_reg <= state_next;
      status_reg <= status_next;
      latch_reg <= latch_next;
      count_reg <= count_next;
    end
  end

  assign status_o = status_reg;

  // apb slave: one wait state, answer on second access cycle
  aop_pkg::aop_ctrl_t ctrl_reg;
  aop_pkg::aop_ctrl_t ctrl_next;
  logic pready_reg;
  logic pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic access;
  logic mapped;

  always_comb begin
    access = psel_i && penable_i && !pready_reg;
    mapped = (paddr_i == aop_pkg::OFS_CTRL) || (paddr_i == aop_pkg::OFS_RESULT) ||
             (paddr_i == aop_pkg::OFS_COUNT);
    pready_next = access;
    pslverr_next = access && !mapped;
    prdata_next = 32'h0000_0000;
    ctrl_next = ctrl_reg;
    if (access && !pwrite_i) begin
      unique case (paddr_i)
        aop_pkg::OFS_CTRL: begin
          prdata_next[aop_pkg::CTRL_TEST_BIT] = ctrl_reg.force_test;
          prdata_next[aop_pkg::CTRL_OFF_BIT] = ctrl_reg.output_off;
        end
        aop_pkg::OFS_RESULT: begin
          prdata_next[aop_pkg::MAG_W+1:0] = latch_reg;
          prdata_next[aop_pkg::RES_STATUS_BIT] = status_reg;
          prdata_next[aop_pkg::RES_PHASE_LSB +: 4] = analog_phase_i;
        end
        aop_pkg::OFS_COUNT: begin
          prdata_next[15:0] = count_reg;
        end
        default: begin
          prdata_next = 32'h0000_0000;
        end
      endcase
    end
    // write lands on the edge the master sees pready high
    if (psel_i && penable_i && pready_reg && pwrite_i && paddr_i == aop_pkg::OFS_CTRL) begin
      ctrl_next.force_test = pwdata_i[aop_pkg::CTRL_TEST_BIT];
      ctrl_next.output_off = pwdata_i[aop_pkg::CTRL_OFF_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_reg <= aop_pkg::CTRL_RESET;
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready_o = pready_reg;
  assign prdata_o = prdata_reg;
  assign pslverr_o = pslverr_reg;

  // byte lanes; software test or disable bits combine with the pins
  logic test_active;
  logic master_on;
  logic [7:0] low_data;
  logic [5:0] high_data;
  logic low_en;
  logic high_en;

  always_comb begin
    test_active = !test_n_i || ctrl_reg.force_test;
    master_on = !chip_enable_n_i && !ctrl_reg.output_off;
    low_en = master_on && !low_byte_gate_n_i;
    high_en = master_on && !high_byte_gate_n_i;
    // test mode drives ones but still obeys the gates, so bus contention cannot arise
    low_data = test_active ? 8'hFF : latch_reg.magnitude[7:0];
    high_data = test_active ? 6'h3F : {latch_reg.sign_flag, latch_reg.over_range, latch_reg.magnitude[11:8]};
  end

  aop_lane #(.W(aop_pkg::LOW_W)) u_low (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .data_i(low_data),
    .enable_i(low_en),
    .data_o(result_low_o),
    .oe_n_o(low_oe_n_o)
  );

  aop_lane #(.W(aop_pkg::HIGH_W)) u_high (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .data_i(high_data),
    .enable_i(high_en),
    .data_o(result_high_o),
    .oe_n_o(high_oe_n_o)
  );

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_conv_end;
    status_o ##1 !status_o;
  endsequence

  sequence s_measure;
    analog_phase_i == aop_pkg::PH_INTEGRATE;
  endsequence

  sequence s_quiet_start;
    !status_o && analog_phase_i != aop_pkg::PH_INTEGRATE;
  endsequence

  sequence s_busy_run;
    status_o && !in_quiet_phase;
  endsequence

  sequence s_conv_walk;
    s_measure ##1 analog_phase_i == aop_pkg::PH_DEINTEGRATE ##1 in_quiet_phase;
  endsequence

  // lanes copy the latch one edge late, so lane checks look one cycle on
  sequence s_high_live;
    high_en && !test_active;
  endsequence

  sequence s_low_forced;
    test_active && low_en;
  endsequence

  sequence s_high_forced;
    test_active && high_en;
  endsequence

  // a control write lands on the edge where the master sees pready high
  sequence s_ctrl_write;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == aop_pkg::OFS_CTRL;
  endsequence

  // indicator is registered, so it trails the phase by one edge
  a_status_rise: assert property (s_measure |=> status_o)
    else $error("indicator not high after integrate");
  a_status_hold: assert property (status_o && analog_phase_i == aop_pkg::PH_DEINTEGRATE |=> status_o)
    else $error("indicator dropped during de-integrate");
  a_status_idle: assert property (s_quiet_start |=> !status_o)
    else $error("indicator rose without integrate");
  a_status_stay: assert property (s_busy_run |=> status_o)
    else $error("indicator dropped before quiet phase");
  a_status_quiet: assert property (in_quiet_phase |=> !status_o)
    else $error("indicator high in quiet phase");
  a_conv_walk: assert property (s_conv_walk |=> !status_o && $past(status_o))
    else $error("indicator did not fall after a full conversion");

  // result latch
  a_sign_latch: assert property (s_conv_end |-> latch_reg.sign_flag == $past(conv_positive_i))
    else $error("sign latched wrongly");
  a_over_latch: assert property (s_conv_end |->
    latch_reg.over_range == ($past(conv_count_i) > aop_pkg::FULL_SCALE))
    else $error("over-range latched wrongly");
  a_mag_latch: assert property (s_conv_end |->
    latch_reg.magnitude == $past(conv_count_i[aop_pkg::MAG_W-1:0]))
    else $error("magnitude latched wrongly");
  a_latch_still: assert property (!(status_reg && !status_next) |=> $stable(latch_reg))
    else $error("latch changed outside conversion end");
  a_latch_when: assert property (!$stable(latch_reg) |-> $fell(status_o))
    else $error("latch changed while indicator steady");

  // byte lanes
  a_mag_order: assert property (low_en && high_en && !test_active |=>
    {result_high_o[3:0], result_low_o} == $past(latch_reg.magnitude))
    else $error("magnitude bit order wrong");
  a_sign_out: assert property (s_high_live |=> result_high_o[5] == $past(latch_reg.sign_flag))
    else $error("sign lane bit wrong");
  a_over_out: assert property (s_high_live |=> result_high_o[4] == $past(latch_reg.over_range))
    else $error("over-range lane bit wrong");
  a_test_force: assert property (!test_n_i && low_en && high_en |=>
    result_low_o == 8'hFF && result_high_o == 6'h3F)
    else $error("test did not force ones");
  a_test_low: assert property (s_low_forced |=> result_low_o == 8'hFF)
    else $error("low lane not forced high");
  a_test_high: assert property (s_high_forced |=> result_high_o == 6'h3F)
    else $error("high lane not forced high");
  a_low_gate: assert property (!chip_enable_n_i && !ctrl_reg.output_off && !low_byte_gate_n_i |=>
    !low_oe_n_o)
    else $error("low lane not enabled");
  a_low_off: assert property (low_byte_gate_n_i |=> low_oe_n_o)
    else $error("low lane driven with its gate high");
  a_high_gate: assert property (!chip_enable_n_i && !ctrl_reg.output_off && !high_byte_gate_n_i |=>
    !high_oe_n_o)
    else $error("high lane not enabled");
  a_high_off: assert property (high_byte_gate_n_i |=> high_oe_n_o)
    else $error("high lane driven with its gate high");
  a_master_off: assert property (chip_enable_n_i |=> low_oe_n_o && high_oe_n_o)
    else $error("lane driven with master enable high");
  a_master_soft: assert property (ctrl_reg.output_off |=> low_oe_n_o && high_oe_n_o)
    else $error("lane driven with output off bit set");

  // control register
  a_ctrl_write: assert property (s_ctrl_write |=>
    ctrl_reg.force_test == $past(pwdata_i[aop_pkg::CTRL_TEST_BIT]) &&
    ctrl_reg.output_off == $past(pwdata_i[aop_pkg::CTRL_OFF_BIT]))
    else $error("control write not taken");
endmodule
`default_nettype wire

// File: src/aop_pkg.sv
// shared constants and types for the converter result output port
`default_nettype none
package aop_pkg;
  localparam int MAG_W = 12;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 6;
  localparam logic [12:0] FULL_SCALE = 13'h0FFF;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_OFF_BIT = 1;
  localparam int RES_STATUS_BIT = 16;
  localparam int RES_PHASE_LSB = 20;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // analog section phase as reported by the converter core
  typedef enum logic [3:0] {
    PH_AUTO_ZERO = 4'b0001,
    PH_INTEGRATE = 4'b0010,
    PH_DEINTEGRATE = 4'b0100,
    PH_ZERO_INT = 4'b1000
  } aop_phase_t;

  typedef enum logic [1:0] {
    ST_QUIET = 2'b01,
    ST_BUSY = 2'b10
  } aop_state_t;

  // magnitude[11] is magnitude_msb, magnitude[0] is magnitude_lsb
  typedef struct packed {
    logic sign_flag;
    logic over_range;
    logic [MAG_W-1:0] magnitude;
  } aop_result_t;

  typedef struct packed {
    logic output_off;
    logic force_test;
  } aop_ctrl_t;
endpackage
`default_nettype wire

// File: src/aop_lane.sv
// one registered three-state byte lane of the result port
`default_nettype none
module aop_lane #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] data_i,
  input wire logic enable_i,
  output logic [W-1:0] data_o,
  output logic oe_n_o
);
  logic [W-1:0] data_reg;
  logic [W-1:0] data_next;
  logic oe_n_reg;
  logic oe_n_next;

  // data held at zero while released, so a floating lane never leaks old values
  always_comb begin
    oe_n_next = ~enable_i;
    data_next = enable_i ? data_i : '0;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_reg <= '0;
      oe_n_reg <= 1'b1;
    end else begin
      data_reg <= data_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign data_o = data_reg;
  assign oe_n_o = oe_n_reg;
endmodule
`default_nettype wire

// File: verif/aop_host_model.sv
// host bus model that gates the result lanes and resolves the three-state wires
`default_nettype none
module aop_host_model (
  input wire logic clock_i,
  input wire logic cs_i,
  input wire logic low_i,
  input wire logic high_i,
  input wire logic [7:0] result_low_i,
  input wire logic low_oe_n_i,
  input wire logic [5:0] result_high_i,
  input wire logic high_oe_n_i,
  output logic chip_enable_n_o,
  output logic low_byte_gate_n_o,
  output logic high_byte_gate_n_o,
  output logic [7:0] bus_low_o,
  output logic [5:0] bus_high_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_low = 8'h00;
  logic [5:0] last_high = 6'h00;
  initial begin
    chip_enable_n_o = 1'b1;
    low_byte_gate_n_o = 1'b1;
    high_byte_gate_n_o = 1'b1;
  end
  always @(posedge clock_i) begin
    chip_enable_n_o <= !cs_i;
    low_byte_gate_n_o <= !low_i;
    high_byte_gate_n_o <= !high_i;
    if (!low_oe_n_i) last_low <= result_low_i;
    if (!high_oe_n_i) last_high <= result_high_i;
  end
  // no pull on these wires, so a floating lane shows the inverse, never a stale match
  assign bus_low_o = low_oe_n_i ? ~last_low : result_low_i;
  assign bus_high_o = high_oe_n_i ? ~last_high : result_high_i;
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the converter result output port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  aop_pkg::aop_phase_t ph = aop_pkg::PH_AUTO_ZERO;
  logic [12:0] cnt = 13'h0000;
  logic pos = 1'b0, test_n = 1'b1, cs = 1'b0, lo = 1'b0, hi = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic ce_n, lg_n, hg_n, st, loe_n, hoe_n, rdy, err, e;
  logic [7:0] rl, bl, pa = 8'h00;
  logic [5:0] rh, bh;
  logic [31:0] pwd = 32'h0, prd, r;
  int failures = 0;
  int compares = 0;
  always #12.5 clock_i = ~clock_i;
  aop_port u_dut (.clock_i(clock_i), .rst_i(rst_i), .analog_phase_i(ph), .conv_count_i(cnt),
    .conv_positive_i(pos), .test_n_i(test_n), .chip_enable_n_i(ce_n), .low_byte_gate_n_i(lg_n),
    .high_byte_gate_n_i(hg_n), .status_o(st), .result_low_o(rl), .low_oe_n_o(loe_n),
    .result_high_o(rh), .high_oe_n_o(hoe_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err));
  aop_host_model u_host (.clock_i(clock_i), .cs_i(cs), .low_i(lo), .high_i(hi), .result_low_i(rl),
    .low_oe_n_i(loe_n), .result_high_i(rh), .high_oe_n_i(hoe_n), .chip_enable_n_o(ce_n),
    .low_byte_gate_n_o(lg_n), .high_byte_gate_n_o(hg_n), .bus_low_o(bl), .bus_high_o(bh));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (rdy !== 1'b1);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // request travels through the host model register, then the lane register
  task gates(input logic c, input logic l, input logic h, input logic [1:0] eoe);
    cs <= c;
    lo <= l;
    hi <= h;
    repeat (4) @(posedge clock_i);
    chk({loe_n, hoe_n}, eoe);
  endtask
  task lanes(input logic [7:0] el, input logic [5:0] eh);
    repeat (4) @(posedge clock_i);
    chk(bl, el);
    chk(bh, eh);
  endtask
  task conv(input logic [12:0] c, input logic p, input logic [7:0] old_lo);
    @(posedge clock_i);
    ph <= aop_pkg::PH_INTEGRATE;
    repeat (2) @(posedge clock_i);
    chk(st, 1'b1);
    ph <= aop_pkg::PH_DEINTEGRATE;
    cnt <= c;
    pos <= p;
    @(posedge clock_i);
    chk(st, 1'b1);
    chk(bl, old_lo);
    ph <= aop_pkg::PH_ZERO_INT;
    repeat (2) @(posedge clock_i);
    chk(st, 1'b0);
    ph <= aop_pkg::PH_AUTO_ZERO;
  endtask
  task tally_and_finish;
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    chk({st, loe_n, hoe_n}, 3'b011);
    @(posedge clock_i);
    ph <= aop_pkg::PH_DEINTEGRATE;
    repeat (3) @(posedge clock_i);
    chk(st, 1'b0);
    ph <= aop_pkg::PH_AUTO_ZERO;
    apb(1'b0, aop_pkg::OFS_CTRL, 32'h0);
    chk(r, {30'h0, aop_pkg::CTRL_RESET});
    gates(1'b1, 1'b1, 1'b1, 2'b00);
    conv(13'h0ABC, 1'b1, 8'h00);
    lanes(8'hBC, 6'h2A);
    conv(13'h1005, 1'b0, 8'hBC);
    lanes(8'h05, 6'h10);
    apb(1'b0, aop_pkg::OFS_RESULT, 32'h0);
    chk(r, 32'h0010_1005);
    apb(1'b0, aop_pkg::OFS_COUNT, 32'h0);
    chk(r, 32'h0000_0002);
    gates(1'b1, 1'b1, 1'b0, 2'b01);
    gates(1'b1, 1'b0, 1'b1, 2'b10);
    gates(1'b1, 1'b1, 1'b1, 2'b00);
    test_n <= 1'b0;
    lanes(8'hFF, 6'h3F);
    test_n <= 1'b1;
    lanes(8'h05, 6'h10);
    apb(1'b1, aop_pkg::OFS_CTRL, 32'h1);
    lanes(8'hFF, 6'h3F);
    apb(1'b1, aop_pkg::OFS_CTRL, 32'h2);
    gates(1'b1, 1'b1, 1'b1, 2'b11);
    apb(1'b1, aop_pkg::OFS_CTRL, 32'h0);
    gates(1'b0, 1'b1, 1'b1, 2'b11);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
